// ---- verilog/nfh_pkg.sv ----
// constants, types and helper functions for the nand flash host controller
// assumes one 20 MHz clock and a device that latches on strobe edges only
package nfh_pkg;

  // clock and pin timing in ns
  localparam int CLK_NS = 50;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int T_RP_NS = 12;
  localparam int T_REH_NS = 10;
  localparam int T_WHR_NS = 60;

  // least time in ns to whole clock cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int STROBE_LOW_CYC = (cyc_min(T_WP_NS) > cyc_min(T_RP_NS)) ? cyc_min(T_WP_NS) : cyc_min(T_RP_NS);
  localparam int STROBE_HIGH_CYC = (cyc_min(T_WH_NS) > cyc_min(T_REH_NS)) ? cyc_min(T_WH_NS) : cyc_min(T_REH_NS);
  localparam int TURN_GAP_CYC = cyc_min(T_WHR_NS);

  // device commands
  localparam logic [7:0] CMD_CACHE_RD = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;

  // address layout
  localparam int COL_W = 12;
  localparam int ROW_W = 17;
  localparam logic [2:0] ADDR_LAST_IDX = 3'h4;

  // controller registers, byte offsets on the axi4-lite bus
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_COL = 8'h04;
  localparam logic [7:0] REG_ROW = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_RDGO = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_CFG = 8'h18;

  // fields
  localparam int CMD_FINAL_BIT = 8;
  localparam int STAT_ENGINE = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_RST_NEED = 3;
  localparam int STAT_CACHE_RD = 4;
  localparam int CFG_CE = 0;
  localparam int CFG_WP = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {NFH_K_CMD, NFH_K_ADDR, NFH_K_DWR, NFH_K_DRD} nfh_kind_t;

  // one of the five address bytes, upper unused bits forced low
  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [COL_W-1:0] col,
                                           input logic [ROW_W-1:0] row);
    case (idx)
      3'h0: return col[7:0];
      3'h1: return {4'h0, col[11:8]};
      3'h2: return row[7:0];
      3'h3: return row[15:8];
      default: return {7'h00, row[16]};
    endcase
  endfunction

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ---- verilog/nfh_cycle.sv ----
// one strobe cycle on the flash pins: command, address, data in or data out
// assumes start only while busy is low; io_in comes straight from the pins
module nfh_cycle #(
  parameter int LOW_CYC = nfh_pkg::STROBE_LOW_CYC, // strobe low phase in cycles
  parameter int HIGH_CYC = nfh_pkg::STROBE_HIGH_CYC, // strobe high hold in cycles
  parameter int GAP_CYC = nfh_pkg::TURN_GAP_CYC // bus turnaround after a cycle
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic start, // begin one cycle
  input wire nfh_pkg::nfh_kind_t kind, // kind of cycle
  input wire logic [7:0] wr_byte, // byte to drive
  input wire logic [7:0] io_in, // byte port level from pins
  output logic cle, // command latch select
  output logic ale, // address latch select
  output logic we_n, // write strobe, low active
  output logic read_strobe_n, // read strobe, low active
  output logic [7:0] io_out, // byte port drive value
  output logic io_oe, // byte port drive enable
  output logic [7:0] rd_byte, // last byte read
  output logic busy, // cycle in progress
  output logic done // one-cycle pulse at end
);
  import nfh_pkg::*;

  typedef enum logic [1:0] {CY_IDLE, CY_LOW, CY_HIGH, CY_GAP} nfh_cy_state_t;

  if (LOW_CYC < 1 || LOW_CYC > 16 || HIGH_CYC < 1 || HIGH_CYC > 16 || GAP_CYC < 1 || GAP_CYC > 16) begin : g_chk
    $error("nfh_cycle: phase lengths must be 1 to 16");
  end
  if (HIGH_CYC + GAP_CYC < 2) begin : g_chk_rd
    $error("nfh_cycle: read capture needs two cycles after the strobe");
  end

  localparam logic [3:0] LOW_N = 4'(LOW_CYC - 1);
  localparam logic [3:0] HIGH_N = 4'(HIGH_CYC - 1);
  localparam logic [3:0] GAP_N = 4'(GAP_CYC - 1);

  nfh_cy_state_t state;
  logic [3:0] cnt;
  logic is_rd;
  logic [7:0] io_s1;
  logic [7:0] io_s2;
  logic [1:0] rd_pipe;

  // phase decode
  wire logic last = (cnt == 4'h0);
  wire logic low_end = (state == CY_LOW) && last;

  assign busy = (state != CY_IDLE);

  // byte port synchroniser and read capture two edges after the strobe rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      rd_pipe <= 2'h0;
      rd_byte <= 8'h00;
    end else begin
      io_s1 <= io_in;
      io_s2 <= io_s1;
      rd_pipe <= {rd_pipe[0], low_end && is_rd};
      if (rd_pipe[1]) begin
        rd_byte <= io_s2;
      end
    end
  end

  // phase sequencer; pins change only on phase boundaries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CY_IDLE;
      cnt <= 4'h0;
      is_rd <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        CY_IDLE: if (start) begin
          state <= CY_LOW;
          cnt <= LOW_N;
          is_rd <= (kind == NFH_K_DRD);
          cle <= (kind == NFH_K_CMD);
          ale <= (kind == NFH_K_ADDR);
          we_n <= (kind == NFH_K_DRD);
          read_strobe_n <= (kind != NFH_K_DRD);
          io_out <= wr_byte;
          io_oe <= (kind != NFH_K_DRD);
        end
        CY_LOW: if (last) begin
          state <= CY_HIGH;
          cnt <= HIGH_N;
          we_n <= 1'b1;
          read_strobe_n <= 1'b1;
        end else begin
          cnt <= cnt - 4'h1;
        end
        CY_HIGH: if (last) begin
          state <= CY_GAP;
          cnt <= GAP_N;
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe <= 1'b0;
        end else begin
          cnt <= cnt - 4'h1;
        end
        CY_GAP: if (last) begin
          state <= CY_IDLE;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 4'h1;
        end
        default: state <= CY_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // the port is never driven while the read strobe is low
  property p_no_drive_on_read;
    !read_strobe_n |-> !io_oe;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("byte port driven during read");

  // a write-type cycle drives exactly the requested byte, unreordered
  property p_byte_order;
    start && !busy && kind != NFH_K_DRD |=> io_oe && io_out == $past(wr_byte) && !we_n;
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("driven byte differs from request");

  // command select stays high across the write strobe rise
  property p_cle_held;
    cle && $rose(we_n) |-> $past(cle) ##1 (cle || state == CY_GAP);
  endproperty
  a_cle_held: assert property (p_cle_held) else $error("command select dropped at strobe rise");

endmodule

// ---- verilog/nfh_host.sv ----
// flash host controller: axi4-lite registers in, flash pins out
// assumes a pull-up on ready_busy_n and a device that keeps its own timing
module nfh_host (
  input wire logic aclk, // system clock, 20 MHz
  input wire logic aresetn, // synchronous reset, low active
  input wire logic [nfh_pkg::AXI_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [nfh_pkg::AXI_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic nand_ce_n, // chip select, low active
  output logic nand_cle, // command latch select
  output logic nand_ale, // address latch select
  output logic nand_we_n, // write strobe, low active
  output logic read_strobe_n, // read strobe, low active
  output logic nand_wp_n, // write protect, low active
  output logic [7:0] byte_port_out, // byte port drive value
  output logic byte_port_oe, // byte port drive enable
  input wire logic [7:0] byte_port_in, // byte port level
  input wire logic ready_busy_n // open-drain ready line, pulled up
);
  import nfh_pkg::*;

  typedef enum logic [1:0] {OP_IDLE, OP_ISSUE, OP_WAIT} nfh_op_state_t;

  nfh_op_state_t op_state;
  nfh_kind_t op_kind;
  logic [7:0] op_byte;
  logic [2:0] op_idx;
  logic [COL_W-1:0] col;
  logic [ROW_W-1:0] row;
  logic [1:0] cfg;
  logic refused;
  logic rst_need;
  logic cache_rd;
  logic last_status;
  logic rb_s1;
  logic rb_s2;
  logic aw_full;
  logic w_full;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic eng_busy;
  logic eng_done;
  logic [7:0] rd_byte;

  // ready line: host only reads it, released high means ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
    end
  end
  wire logic dev_ready = rb_s2;

  // write channel capture and decode
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  wire logic wr_fire = aw_full && w_full && !s_axi_bvalid && (op_state == OP_IDLE);
  wire logic sel_cmd = wr_fire && (aw_addr == REG_CMD);
  wire logic sel_col = wr_fire && (aw_addr == REG_COL);
  wire logic sel_row = wr_fire && (aw_addr == REG_ROW);
  wire logic sel_data = wr_fire && (aw_addr == REG_DATA);
  wire logic sel_rdgo = wr_fire && (aw_addr == REG_RDGO);
  wire logic sel_stat = wr_fire && (aw_addr == REG_STAT);
  wire logic sel_cfg = wr_fire && (aw_addr == REG_CFG);
  wire logic wr_mapped = sel_cmd || sel_col || sel_row || sel_data || sel_rdgo || sel_stat || sel_cfg;

  // gating of orders against device state
  wire logic [7:0] w_cmd = w_data[7:0];
  wire logic w_final = w_data[CMD_FINAL_BIT];
  wire logic cmd_safe = (w_cmd == CMD_STATUS) || (w_cmd == CMD_RESET);
  wire logic cmd_bad = (!cmd_safe && (!dev_ready || rst_need)) || (w_final && w_cmd == CMD_CACHE_RD);
  wire logic addr_bad = !dev_ready || rst_need;
  wire logic data_bad = !dev_ready || rst_need;
  wire logic rd_bad = !dev_ready && !last_status;
  wire logic go_cmd = sel_cmd && !cmd_bad;
  wire logic go_addr = sel_row && !addr_bad;
  wire logic go_data = sel_data && !data_bad;
  wire logic go_rd = sel_rdgo && !rd_bad;
  wire logic set_ref = (sel_cmd && cmd_bad) || (sel_row && addr_bad) || (sel_data && data_bad) || (sel_rdgo && rd_bad);
  wire logic clr_ref = sel_stat && w_data[STAT_REFUSED];
  wire logic [31:0] col_new = merge(32'(col), w_data, w_strb);
  wire logic [31:0] row_new = merge(32'(row), w_data, w_strb);
  wire logic [31:0] cfg_new = merge(32'(cfg), w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // controller registers and flags; a set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      col <= '0;
      row <= '0;
      cfg <= CFG_RESET;
      refused <= 1'b0;
      rst_need <= 1'b0;
      cache_rd <= 1'b0;
      last_status <= 1'b0;
    end else begin
      if (sel_col) begin
        col <= col_new[COL_W-1:0];
      end
      if (sel_row) begin
        row <= row_new[ROW_W-1:0];
      end
      if (sel_cfg) begin
        cfg <= cfg_new[1:0];
      end
      refused <= set_ref || (refused && !clr_ref);
      if (go_cmd) begin
        last_status <= (w_cmd == CMD_STATUS);
        if (w_final && w_cmd == CMD_PROG_CACHE) begin
          rst_need <= 1'b1;
        end else if (w_cmd == CMD_RESET) begin
          rst_need <= 1'b0;
        end
        if (w_cmd == CMD_CACHE_RD) begin
          cache_rd <= 1'b1;
        end else if (w_cmd == CMD_CACHE_LAST || w_cmd == CMD_RESET) begin
          cache_rd <= 1'b0;
        end
      end
    end
  end

  // order sequencer: one pin cycle, or five for an address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_state <= OP_IDLE;
      op_kind <= NFH_K_CMD;
      op_byte <= 8'h00;
      op_idx <= 3'h0;
    end else begin
      case (op_state)
        OP_IDLE: if (go_cmd || go_addr || go_data || go_rd) begin
          op_state <= OP_ISSUE;
          op_idx <= 3'h0;
          op_byte <= w_data[7:0];
          op_kind <= go_cmd ? NFH_K_CMD : go_addr ? NFH_K_ADDR : go_data ? NFH_K_DWR : NFH_K_DRD;
        end
        OP_ISSUE: op_state <= OP_WAIT;
        OP_WAIT: if (eng_done) begin
          if (op_kind == NFH_K_ADDR && op_idx != ADDR_LAST_IDX) begin
            op_idx <= op_idx + 3'h1;
            op_state <= OP_ISSUE;
          end else begin
            op_state <= OP_IDLE;
          end
        end
        default: op_state <= OP_IDLE;
      endcase
    end
  end

  // byte handed to the pin engine
  wire logic eng_start = (op_state == OP_ISSUE);
  wire logic [7:0] eng_byte = (op_kind == NFH_K_ADDR) ? addr_byte(op_idx, col, row) : op_byte;

  nfh_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(eng_start),
    .kind(op_kind),
    .wr_byte(eng_byte),
    .io_in(byte_port_in),
    .cle(nand_cle),
    .ale(nand_ale),
    .we_n(nand_we_n),
    .read_strobe_n(read_strobe_n),
    .io_out(byte_port_out),
    .io_oe(byte_port_oe),
    .rd_byte(rd_byte),
    .busy(eng_busy),
    .done(eng_done)
  );

  // static pins from the configuration register
  assign nand_ce_n = !cfg[CFG_CE];
  assign nand_wp_n = cfg[CFG_WP];

  // read channel
  wire logic [31:0] stat_word = {27'h0, cache_rd, rst_need, refused, dev_ready, eng_busy || op_state != OP_IDLE};
  wire logic [AXI_AW-1:0] ra = s_axi_araddr;
  wire logic rd_mapped = (ra == REG_CMD) || (ra == REG_COL) || (ra == REG_ROW) || (ra == REG_DATA) ||
                         (ra == REG_RDGO) || (ra == REG_STAT) || (ra == REG_CFG);
  wire logic [31:0] rd_word = (ra == REG_COL) ? 32'(col) : (ra == REG_ROW) ? 32'(row) :
                              (ra == REG_DATA) ? 32'(rd_byte) : (ra == REG_STAT) ? stat_word :
                              (ra == REG_CFG) ? 32'(cfg) : 32'h0;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_busy_filter;
    sel_cmd && !dev_ready && !cmd_safe |=> refused && op_state == OP_IDLE;
  endproperty
  a_busy_filter: assert property (p_busy_filter) else $error("command sent while device busy");

  property p_addr_pad;
    eng_start && op_kind == NFH_K_ADDR && op_idx == 3'h1 |-> eng_byte[7:4] == 4'h0 ##1 eng_busy;
  endproperty
  a_addr_pad: assert property (p_addr_pad) else $error("second address byte upper bits set");

  property p_addr_five;
    go_addr |-> ##[20:60] (op_kind == NFH_K_ADDR && eng_done && op_idx == ADDR_LAST_IDX) ##1 op_state == OP_IDLE;
  endproperty
  a_addr_five: assert property (p_addr_five) else $error("address not sent as five cycles");

  property p_reset_lock;
    rst_need && sel_cmd && !cmd_safe |=> refused && $stable(rst_need);
  endproperty
  a_reset_lock: assert property (p_reset_lock) else $error("order accepted before reset");

  property p_cache_end;
    sel_cmd && w_final && w_cmd == CMD_CACHE_RD |=> refused ##1 !eng_busy;
  endproperty
  a_cache_end: assert property (p_cache_end) else $error("cached read closed without last-page command");

  c_cmd: cover property (go_cmd ##[1:20] eng_done);
  c_addr: cover property (go_addr ##[20:60] (op_state == OP_IDLE));
  c_read: cover property (go_rd ##[1:20] eng_done);
  c_refuse: cover property ($rose(refused));

endmodule

// ---- verif/nfh_dev_model.sv ----
// behavioural flash device seen from the host controller pins
// assumes the bench resolves the byte port and pulls the ready line up
module nfh_dev_model #(
  parameter int BUSY_NS = 5000 // busy span in ns
) (
  input wire logic nand_ce_n, // chip select, low active
  input wire logic nand_cle, // command latch select
  input wire logic nand_ale, // address latch select
  input wire logic nand_we_n, // write strobe, low active
  input wire logic read_strobe_n, // read strobe, low active
  input wire logic nand_wp_n, // write protect, low active
  input wire logic [7:0] byte_port_in, // byte port level
  output logic [7:0] dev_byte, // byte offered on the port
  output logic dev_oe, // device drives the port
  output logic rb_pull // pulls ready_busy_n low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cmd = 8'h00;
  logic [2:0] aidx = 3'h0;
  logic [11:0] col = 12'h000;
  logic [16:0] row = 17'h00000;
  logic [5:0] pg;
  logic [10:0] blk;
  logic standby;
  time t_cache = 0;
  time busy_end = 0;
  int ovl;
  bit cache_pend = 1'b0;
  initial begin
    dev_byte = 8'h00;
    dev_oe = 1'b0;
    rb_pull = 1'b0;
  end
  // standby only while ready
  assign standby = nand_ce_n && !rb_pull;
  // busy span of an array operation; overlapping spans merge so a short one never cuts a long one
  task automatic go_busy(input int ns);
    if ($time + ns > busy_end) busy_end = $time + ns;
    rb_pull = 1'b1;
    fork
      begin
        #(ns);
        if ($time >= busy_end) rb_pull = 1'b0;
      end
    join_none
  endtask
  // latch commands and address bytes on write strobe rise
  always @(posedge nand_we_n) begin
    if (!nand_ce_n && nand_cle) begin
      cmd = byte_port_in;
      aidx = 3'h0;
      if (byte_port_in == 8'hff) cache_pend = 1'b0;
      if (byte_port_in == 8'h30) go_busy(BUSY_NS);
      if (nand_wp_n && (byte_port_in == 8'h10 || byte_port_in == 8'h15 || byte_port_in == 8'hd0)) begin
        {blk, pg} = row;
        // a closing page after a cached one also waits out the previous page, less the input overlap
        ovl = int'($time - t_cache);
        if (cache_pend && byte_port_in == 8'h10) go_busy((ovl > BUSY_NS) ? BUSY_NS : 2 * BUSY_NS - ovl);
        else go_busy(BUSY_NS);
        cache_pend = (byte_port_in == 8'h15);
        t_cache = $time;
      end
    end else if (!nand_ce_n && nand_ale) begin
      case (aidx)
        3'h0: col[7:0] = byte_port_in;
        3'h1: col[11:8] = byte_port_in[3:0];
        3'h2: row[7:0] = byte_port_in;
        3'h3: row[15:8] = byte_port_in;
        default: row[16] = byte_port_in[0];
      endcase
      aidx = aidx + 3'h1;
    end
  end
  // next byte after the access delay on read strobe fall
  always @(negedge read_strobe_n) begin
    if (!nand_ce_n) begin
      #20;
      dev_oe = 1'b1;
      dev_byte = (cmd == 8'h70) ? {2'b00, !rb_pull, 5'h00} : (col[7:0] ^ row[7:0]);
      if (cmd != 8'h70 && col < 12'd2175) col = col + 12'h001;
    end
  end
  // let go of the port after the hold time, leaving a changed value
  always @(posedge read_strobe_n) begin
    #25;
    dev_oe = 1'b0;
    dev_byte = ~dev_byte;
  end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench: host controller, device model and register traffic
// assumes the design package, design modules and device model compile first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import nfh_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nand_ce_n, nand_cle, nand_ale, nand_we_n;
  logic read_strobe_n, nand_wp_n, byte_port_oe, dev_oe, rb_pull;
  logic [7:0] s_axi_awaddr, s_axi_araddr, byte_port_out, dev_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [11:0] c;
  logic [16:0] rw;
  logic [8:0] lead [2] = '{9'h080, 9'h081};
  wire [7:0] byte_port_in;
  tri1 ready_busy_n;
  int mismatches, checks_done;
  // resolve the shared port and the pulled-up ready line
  assign byte_port_in = byte_port_oe ? byte_port_out : dev_byte;
  assign ready_busy_n = rb_pull ? 1'b0 : 1'bz;
  nfh_host i_dut (.*);
  nfh_dev_model i_dev (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    check("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic cmd(input logic [8:0] v);
    wr(REG_CMD, {23'h0, v}, RESP_OKAY);
  endtask
  task automatic wait_stat(input int b, input logic v);
    do rd(REG_STAT, d, r); while (d[b] !== v);
  endtask
  task automatic wait_rdy();
    wait_stat(STAT_ENGINE, 1'b0);
    wait_stat(STAT_READY, 1'b1);
  endtask
  task automatic stat_bit(input int b, input logic e, input string w);
    rd(REG_STAT, d, r);
    check(w, d[b], e);
  endtask
  // port clash and strobes during busy
  always @(posedge aclk) begin
    if (byte_port_oe === 1'b1 && dev_oe) check("port clash", 1, 0);
    if (nand_we_n === 1'b0 && ready_busy_n === 1'b0 &&
        !(nand_cle && (byte_port_out == 8'h70 || byte_port_out == 8'hff))) begin
      check("strobe in busy", 1, 0);
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    final_report();
  end
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(32'h7c37));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_CFG, d, r);
    check("cfg reset", d, {30'h0, CFG_RESET});
    check("ce_n idle", nand_ce_n, 1'b1);
    rd(8'h1c, d, r);
    check("rresp unmapped", r, RESP_SLVERR);
    wr(8'h1c, 32'h3, RESP_SLVERR);
    wr(REG_CFG, 32'h3, RESP_OKAY);
    check("wp_n", nand_wp_n, 1'b1);
    for (int p = 0; p < 2; p++) begin
      c = p ? 12'($urandom_range(2171)) : 12'd2172;
      rw = 17'($urandom);
      cmd(9'h000);
      wr(REG_COL, {20'h0, c}, RESP_OKAY);
      wr(REG_ROW, {15'h0, rw}, RESP_OKAY);
      cmd(9'h030);
      wait_rdy();
      check("col latched", i_dev.col, c);
      check("row latched", i_dev.row, rw);
      for (int k = 0; k < 4; k++) begin
        wr(REG_RDGO, 32'h0, RESP_OKAY);
        wait_rdy();
        rd(REG_DATA, d, r);
        check("read byte", d[7:0], 8'(c + k) ^ rw[7:0]);
      end
    end
    cmd(9'h080);
    wr(REG_ROW, {15'h0, rw}, RESP_OKAY);
    wr(REG_DATA, $urandom, RESP_OKAY);
    cmd(9'h010);
    wait_stat(STAT_READY, 1'b0);
    check("page in block", i_dev.pg, rw[5:0]);
    check("block number", i_dev.blk, rw[16:6]);
    cmd(9'h080);
    stat_bit(STAT_REFUSED, 1'b1, "refused in busy");
    cmd(9'h070);
    wr(REG_RDGO, 32'h0, RESP_OKAY);
    wait_stat(STAT_ENGINE, 1'b0);
    rd(REG_DATA, d, r);
    check("status busy bit", d[5], 1'b0);
    wait_rdy();
    wr(REG_STAT, 32'h4, RESP_OKAY);
    stat_bit(STAT_REFUSED, 1'b0, "refused clear");
    foreach (lead[i]) begin
      cmd(lead[i]);
      cmd(9'h115);
      wait_rdy();
      stat_bit(STAT_RST_NEED, 1'b1, "reset needed");
      cmd(9'h080);
      stat_bit(STAT_REFUSED, 1'b1, "refused locked");
      check("no pin cmd", i_dev.cmd, 8'h15);
      cmd(9'h0ff);
      stat_bit(STAT_RST_NEED, 1'b0, "reset done");
      wr(REG_STAT, 32'h4, RESP_OKAY);
    end
    cmd(9'h031);
    stat_bit(STAT_CACHE_RD, 1'b1, "cache read on");
    cmd(9'h131);
    stat_bit(STAT_REFUSED, 1'b1, "final 31h refused");
    cmd(9'h03f);
    stat_bit(STAT_CACHE_RD, 1'b0, "cache read off");
    wr(REG_CFG, 32'h1, RESP_OKAY);
    check("wp_n low", nand_wp_n, 1'b0);
    cmd(9'h010);
    repeat (4) @(posedge aclk);
    check("no busy when protected", ready_busy_n, 1'b1);
    wr(REG_CFG, 32'h0, RESP_OKAY);
    check("standby", i_dev.standby, 1'b1);
    final_report();
  end
endmodule
